// ===== reset_ctrl.sv
// Reset-source control: power-on delay, supply-sag reset or interrupt, watchdog,
// boot area selection, with APB access to the special function registers.
// Assumes supply_sag_detect and power_ok are already synchronous to pclk.
//
// Summary of operation
// - Extended option adds about 180 ms of reset after power-on delay.
// - Without the option only the ordinary power-on delay is applied.
// - Leaving extended power-on reset sets boot select to monitor area.
// - Sag with reset option resets and sets low-voltage flag bit 5.
// - Low-voltage flag is also set at power-on; software clears it.
// - Low-voltage flag is sticky until software clears it.
// - Sag reset leaves boot select unchanged.
// - Sag without reset option raises interrupt request and sets flag.
// - Sag interrupt may wake device from power-down.
// - EEPROM inhibit option blocks programming while supply is low.
// - Global enable gates all interrupts; sag enable gates sag interrupt.
// - Sag priority bit selects low or high priority.
// - Watchdog is an 8-bit prescaler then a 15-bit counter.
// - Run bit starts the watchdog; clearing it stops counting.
// - Kick restarts the count and self-clears; software kicks in time.
// - Overflow issues system reset and sets sticky watchdog reset flag.
// - Watchdog reset leaves boot select unchanged.
// - Idle-run bit lets watchdog count in idle, else it halts.
// - Prescale code selects division two to the code plus one.
// - Overflow period is 12 times prescale times 32768 clocks.
// - Without the extended option, internal reset releases 32768 clocks after supply recovers.
// - Boot select zero means application area, one means monitor area.
`timescale 1ns/10ps
module reset_ctrl
  import reset_ctrl_pkg::*;
#(
  parameter int por_cycles = por_delay_cycles,
  parameter int ext_cycles = ext_delay_cycles
)
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire option_t     options,
  input  wire logic        power_ok,
  input  wire logic        supply_sag_detect,
  input  wire logic        core_idle,
  input  wire logic        core_power_down,
  input  wire logic        irq_ack,
  output logic             system_reset,
  output logic             boot_source_select,
  output logic             supply_sag_irq,
  output logic             supply_sag_irq_high,
  output logic             wake_request,
  output logic             eeprom_inhibit
);

  // ------------------------------------------------------------
  // Bus decode
  // ------------------------------------------------------------
  logic        wr_en;
  logic        rd_en;
  logic [7:0]  wbyte;

  assign pready  = 1'b1;
  assign wr_en   = psel && penable && pwrite;
  // Reads load prdata in the setup cycle so it stands at the access edge
  assign rd_en   = psel && !penable && !pwrite;
  assign wbyte   = pwdata[7:0];

  // Each register is one aligned word at four times its index
  function automatic logic at(input logic [11:0] a, input logic [11:0] idx);
    at = (a == {idx[9:0], 2'b00});
  endfunction

  function automatic logic mapped(input logic [11:0] a);
    mapped = at(a, power_control_idx) || at(a, interrupt_enable_reg_idx) ||
             at(a, interrupt_priority_reg_idx) || at(a, watchdog_control_idx) ||
             at(a, boot_control_idx) || at(a, status_idx);
  endfunction

  function automatic logic hit(input logic [11:0] a, input logic [11:0] idx);
    hit = wr_en && at(a, idx);
  endfunction

  assign pslverr = psel && penable && !mapped(paddr);

  // ------------------------------------------------------------
  // Reset sequencing
  // ------------------------------------------------------------
  reset_state_t state_q;
  reset_state_t state_d;
  logic [31:0]  delay_q;
  logic         wd_overflow;
  logic         sag_reset_evt;
  logic         sag_q;
  logic         sag_rise;
  logic         cold_release;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sag_q <= 1'b0;
    end else begin
      sag_q <= supply_sag_detect;
    end
  end

  assign sag_rise      = supply_sag_detect && !sag_q;
  assign sag_reset_evt = sag_rise && options.sag_resets && (state_q == st_run);

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      st_por: begin
        if (power_ok && delay_q == 32'(por_cycles - 1)) begin
          state_d = options.ext_delay ? st_ext : st_run;
        end
      end
      st_ext: begin
        if (delay_q == 32'(ext_cycles - 1)) begin
          state_d = st_run;
        end
      end
      st_run: begin
        if (wd_overflow || sag_reset_evt) begin
          state_d = st_sys_rst;
        end
      end
      st_sys_rst: begin
        state_d = st_run;
      end
    endcase
    if (!power_ok) begin
      state_d = st_por;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= st_por;
    end else begin
      state_q <= state_d;
    end
  end

  // One counter serves both delays; it restarts on every state change
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      delay_q <= 32'h0000_0000;
    end else if (state_d != state_q || !power_ok) begin
      delay_q <= 32'h0000_0000;
    end else if (state_q == st_por || state_q == st_ext) begin
      delay_q <= delay_q + 32'h0000_0001;
    end
  end

  assign cold_release = (state_q == st_por || state_q == st_ext) && state_d == st_run;
  assign system_reset = (state_q != st_run);

  // ------------------------------------------------------------
  // Boot area select
  // ------------------------------------------------------------
  logic boot_q;

  // Warm resets never touch this bit; only a cold release or a software write sets it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      boot_q <= 1'b1;
    end else if (cold_release) begin
      boot_q <= 1'b1;
    end else if (hit(paddr, boot_control_idx) && !system_reset) begin
      boot_q <= wbyte[boot_select_bit];
    end
  end

  assign boot_source_select = boot_q;

  // ------------------------------------------------------------
  // Power control flags
  // ------------------------------------------------------------
  logic low_voltage_flag_q;
  logic power_on_flag_q;
  logic [3:0] pc_misc_q;
  logic [1:0] pc_top_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_voltage_flag_q <= 1'b1;
    end else if (state_q == st_por || supply_sag_detect) begin
      low_voltage_flag_q <= 1'b1;
    end else if (hit(paddr, power_control_idx) && !wbyte[pc_low_voltage_flag_bit]) begin
      low_voltage_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      power_on_flag_q <= 1'b1;
    end else if (state_q == st_por) begin
      power_on_flag_q <= 1'b1;
    end else if (hit(paddr, power_control_idx) && !wbyte[pc_power_on_flag_bit]) begin
      power_on_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc_misc_q <= power_control_rst[3:0];
      pc_top_q  <= power_control_rst[7:6];
    end else if (system_reset) begin
      pc_misc_q <= power_control_rst[3:0];
      pc_top_q  <= power_control_rst[7:6];
    end else if (hit(paddr, power_control_idx)) begin
      pc_misc_q <= wbyte[3:0];
      pc_top_q  <= wbyte[7:6];
    end
  end

  // ------------------------------------------------------------
  // Interrupt enable and priority
  // ------------------------------------------------------------
  logic [7:0] ie_q;
  logic [7:0] ip_q;
  logic       sag_pend_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ie_q <= ie_rst;
      ip_q <= ip_rst;
    end else if (system_reset) begin
      ie_q <= ie_rst;
      ip_q <= ip_rst;
    end else begin
      if (hit(paddr, interrupt_enable_reg_idx)) begin
        ie_q <= wbyte;
      end
      if (hit(paddr, interrupt_priority_reg_idx)) begin
        ip_q <= wbyte;
      end
    end
  end

  // New sag wins over an acknowledge in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sag_pend_q <= 1'b0;
    end else if (system_reset) begin
      sag_pend_q <= 1'b0;
    end else if (sag_rise && !options.sag_resets) begin
      sag_pend_q <= 1'b1;
    end else if (irq_ack) begin
      sag_pend_q <= 1'b0;
    end
  end

  assign supply_sag_irq      = sag_pend_q && ie_q[ie_global_bit] && ie_q[ie_sag_bit];
  assign supply_sag_irq_high = supply_sag_irq && ip_q[ip_sag_bit];
  assign wake_request        = supply_sag_irq && core_power_down;
  assign eeprom_inhibit      = options.eeprom_inhibit && supply_sag_detect;

  // ------------------------------------------------------------
  // Watchdog
  // ------------------------------------------------------------
  logic                       wd_flag_q;
  logic                       wd_run_q;
  logic                       wd_idle_run_q;
  logic                       wd_kick_q;
  logic [2:0]                 wd_sel_q;
  logic [wd_counter_bits-1:0] wd_cnt_q;
  logic                       wd_advance;
  logic                       wd_tick;
  logic                       wd_write;

  assign wd_write   = hit(paddr, watchdog_control_idx) && !system_reset;
  // Halted while idle unless idle-run is set
  assign wd_advance = wd_run_q && !system_reset && (!core_idle || wd_idle_run_q);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wd_run_q      <= wd_control_rst[wd_run_bit];
      wd_idle_run_q <= wd_control_rst[wd_idle_run_bit];
      wd_sel_q      <= wd_control_rst[2:0];
    end else if (system_reset) begin
      wd_run_q      <= 1'b0;
      wd_idle_run_q <= 1'b0;
      wd_sel_q      <= 3'h0;
    end else if (wd_write) begin
      wd_run_q      <= wbyte[wd_run_bit];
      wd_idle_run_q <= wbyte[wd_idle_run_bit];
      wd_sel_q      <= wbyte[2:0];
    end
  end

  // Kick is a self-clearing strobe; it reads back as one only for one cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wd_kick_q <= 1'b0;
    end else begin
      wd_kick_q <= wd_write && wbyte[wd_kick_bit];
    end
  end

  wd_prescaler u_pre (
    .pclk    (pclk),
    .presetn (presetn),
    .clear   (wd_kick_q || !wd_run_q),
    .advance (wd_advance),
    .sel     (wd_sel_q),
    .tick    (wd_tick)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wd_cnt_q <= 15'h0000;
    end else if (wd_kick_q || !wd_run_q || system_reset) begin
      wd_cnt_q <= 15'h0000;
    end else if (wd_tick && !wd_kick_q) begin
      wd_cnt_q <= wd_cnt_q + 15'h0001;
    end
  end

  assign wd_overflow = wd_tick && !wd_kick_q && (wd_cnt_q == 15'h7fff);

  // Kept through the watchdog reset so software can tell it from power-on
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wd_flag_q <= 1'b0;
    end else if (wd_overflow) begin
      wd_flag_q <= 1'b1;
    end else if (state_q == st_por) begin
      wd_flag_q <= 1'b0;
    end else if (wd_write && !wbyte[wd_reset_flag_bit]) begin
      wd_flag_q <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Read data
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_en) begin
      unique case (1'b1)
        at(paddr, power_control_idx):
          prdata <= {24'h000000, pc_top_q, low_voltage_flag_q, power_on_flag_q, pc_misc_q};
        at(paddr, interrupt_enable_reg_idx):   prdata <= {24'h000000, ie_q};
        at(paddr, interrupt_priority_reg_idx): prdata <= {24'h000000, ip_q};
        at(paddr, watchdog_control_idx):
          prdata <= {24'h000000, wd_flag_q, 1'b0, wd_run_q, wd_kick_q, wd_idle_run_q, wd_sel_q};
        at(paddr, boot_control_idx):           prdata <= {24'h000000, 1'b0, boot_q, 6'h00};
        at(paddr, status_idx):                 prdata <= {28'h0000000, state_q};
        default:                    prdata <= 32'h0000_0000;
      endcase
    end
  end

endmodule

// ===== reset_ctrl_pkg.sv
// Package: constants, types and register map for the reset-source control block.
// Assumes a 10 MHz APB clock standing in for the system clock.
package reset_ctrl_pkg;

  // ------------------------------------------------------------
  // Register map (register indices; each word sits at four times its index)
  // ------------------------------------------------------------
  localparam logic [11:0] power_control_idx          = 12'h087;
  localparam logic [11:0] interrupt_enable_reg_idx   = 12'h0a8;
  localparam logic [11:0] interrupt_priority_reg_idx = 12'h0b8;
  localparam logic [11:0] watchdog_control_idx       = 12'h0c1;
  localparam logic [11:0] boot_control_idx           = 12'h0c7;
  localparam logic [11:0] status_idx                 = 12'h0d0;

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int pc_low_voltage_flag_bit  = 5;
  localparam int pc_power_on_flag_bit     = 4;
  localparam int pc_idle_bit              = 0;
  localparam int pc_power_down_bit        = 1;
  localparam int ie_global_bit            = 7;
  localparam int ie_sag_bit               = 6;
  localparam int ip_sag_bit               = 6;
  localparam int wd_reset_flag_bit        = 7;
  localparam int wd_run_bit               = 5;
  localparam int wd_kick_bit              = 4;
  localparam int wd_idle_run_bit          = 3;
  localparam int boot_select_bit          = 6;

  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic [7:0] power_control_rst = 8'h30;
  localparam logic [7:0] ie_rst            = 8'h00;
  localparam logic [7:0] ip_rst            = 8'h00;
  localparam logic [7:0] wd_control_rst    = 8'h00;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int clk_hz            = 10_000_000;
  localparam int ext_delay_ms      = 180;
  localparam int ext_delay_cycles  = (clk_hz / 1000) * ext_delay_ms;
  localparam int por_delay_cycles  = 32768;
  localparam int wd_core_div       = 12;
  localparam int wd_counter_bits   = 15;
  localparam int wd_prescale_bits  = 8;

  typedef enum logic [3:0] {
    st_por     = 4'b0001,
    st_ext     = 4'b0010,
    st_run     = 4'b0100,
    st_sys_rst = 4'b1000
  } reset_state_t;

  typedef struct packed {
    logic ext_delay;
    logic sag_resets;
    logic eeprom_inhibit;
  } option_t;

endpackage

// ===== wd_prescaler.sv
// Watchdog front divider: divide-by-12 tick into the 8-bit prescaler.
// Assumes the parent holds it cleared while the watchdog is stopped or kicked.
`timescale 1ns/10ps
module wd_prescaler
  import reset_ctrl_pkg::*;
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       clear,
  input  wire logic       advance,
  input  wire logic [2:0] sel,
  output logic            tick
);

  logic [3:0]                  core_q;
  logic [wd_prescale_bits-1:0] pre_q;
  logic                        core_done;
  logic [8:0]                  limit;

  assign core_done = advance && (core_q == 4'(wd_core_div - 1));
  // Division is two raised to the code plus one
  assign limit = 9'h002 << sel;
  assign tick  = core_done && ({1'b0, pre_q} == limit - 9'h001);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_q <= 4'h0;
    end else if (clear || core_done) begin
      core_q <= 4'h0;
    end else if (advance) begin
      core_q <= core_q + 4'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_q <= 8'h00;
    end else if (clear || tick) begin
      pre_q <= 8'h00;
    end else if (core_done) begin
      pre_q <= pre_q + 8'h01;
    end
  end

endmodule

// ===== reset_ctrl_checker.sv
// Checker: port-level timing rules of the reset-source control block.
// Assumes it is bound to reset_ctrl and sees that module's ports only.
`timescale 1ns/10ps
module reset_ctrl_checker
  import reset_ctrl_pkg::*;
#(
  parameter int por_cycles = por_delay_cycles,
  parameter int ext_cycles = ext_delay_cycles
)
(
  input wire logic    pclk,
  input wire logic    presetn,
  input wire option_t options,
  input wire logic    power_ok,
  input wire logic    supply_sag_detect,
  input wire logic    core_power_down,
  input wire logic    system_reset,
  input wire logic    boot_source_select,
  input wire logic    supply_sag_irq,
  input wire logic    wake_request,
  input wire logic    eeprom_inhibit
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ------------------------------------------------------------
  // Edges of good supply since reset, saturating past the release
  // ------------------------------------------------------------
  int hold_n;
  int cnt_q;
  assign hold_n = por_cycles + (options.ext_delay ? ext_cycles : 0);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 0;
    end else if (power_ok && cnt_q < hold_n + 4) begin
      cnt_q <= cnt_q + 1;
    end
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  AST_POR_HOLD: assert property ((cnt_q + 1 < hold_n) |-> system_reset)
    else $error("reset released before the power-on delay ran out");
  AST_POR_RELEASE: assert property ((cnt_q == hold_n + 3) && !supply_sag_detect |-> !system_reset)
    else $error("reset still held after the power-on delay");
  AST_BOOT_EXT: assert property (options.ext_delay && $fell(system_reset) && cnt_q < hold_n + 4
    |-> ##[0:1] boot_source_select)
    else $error("boot select not monitor area after extended delay");
  AST_SAG_RESET: assert property (options.sag_resets && $rose(supply_sag_detect) && !system_reset
    |-> ##[0:3] system_reset)
    else $error("supply sag did not reset the chip");
  AST_SAG_IRQ_ONLY: assert property (!options.sag_resets && $rose(supply_sag_detect) && !system_reset
    |=> !system_reset [*3])
    else $error("supply sag reset the chip in interrupt mode");
  AST_BOOT_HOLD: assert property ($rose(system_reset)
    |-> $stable(boot_source_select) ##1 $stable(boot_source_select))
    else $error("warm reset changed boot select");
  AST_WARM_PULSE: assert property ($rose(system_reset) && power_ok |=> !system_reset)
    else $error("warm reset longer than one cycle");
  AST_EEPROM: assert property (eeprom_inhibit == (options.eeprom_inhibit && supply_sag_detect))
    else $error("eeprom inhibit does not follow option and supply");
  AST_WAKE: assert property (wake_request |-> core_power_down && supply_sag_irq)
    else $error("wake request outside power-down");

  COV_WARM: cover property ($rose(system_reset));
  COV_IRQ: cover property ($fell(supply_sag_irq));
  COV_WAKE: cover property (wake_request);
endmodule

bind reset_ctrl reset_ctrl_checker #(.por_cycles(por_cycles), .ext_cycles(ext_cycles)) u_chk (
  .pclk(pclk), .presetn(presetn), .options(options), .power_ok(power_ok),
  .supply_sag_detect(supply_sag_detect), .core_power_down(core_power_down),
  .system_reset(system_reset), .boot_source_select(boot_source_select),
  .supply_sag_irq(supply_sag_irq), .wake_request(wake_request), .eeprom_inhibit(eeprom_inhibit)
);

// ===== tb_reset_ctrl.sv
// Testbench: APB master and hand-written scenarios for reset_ctrl.
// Assumes short power-on delays; watchdog overflow is too long to run here.
`timescale 1ns/10ps
module tb_reset_ctrl;
  import reset_ctrl_pkg::*;
  localparam int por_n = 16;
  localparam int ext_n = 20;

  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  option_t     options;
  logic        power_ok, supply_sag_detect, core_idle, core_power_down, irq_ack;
  logic        system_reset, boot_source_select, supply_sag_irq, supply_sag_irq_high;
  logic        wake_request, eeprom_inhibit, err, seen;
  int          error_cnt, total_checks, cyc, n;

  reset_ctrl #(.por_cycles(por_n), .ext_cycles(ext_n)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .options(options), .power_ok(power_ok), .supply_sag_detect(supply_sag_detect),
    .core_idle(core_idle), .core_power_down(core_power_down), .irq_ack(irq_ack),
    .system_reset(system_reset), .boot_source_select(boot_source_select),
    .supply_sag_irq(supply_sag_irq), .supply_sag_irq_high(supply_sag_irq_high),
    .wake_request(wake_request), .eeprom_inhibit(eeprom_inhibit)
  );

  initial pclk = 1'b0;
  always #50 pclk = ~pclk;

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic test_done();
    if (error_cnt == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Takes a register index; read data and error are taken at the access edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1; pwrite <= w; paddr <= {a[9:0], 2'b00}; pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    err = pslverr;
    rd = prdata;
    psel <= 1'b0; penable <= 1'b0;
    @(negedge pclk);
  endtask

  task automatic power_up(input option_t o, input int lo);
    @(posedge pclk);
    presetn <= 1'b0; options <= o;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    n = 0;
    do begin @(posedge pclk); #1 n++; end while (system_reset === 1'b1 && n < 5000);
    chk(32'(n >= lo && n <= lo + 3), 32'h1);
  endtask

  // Two-cycle pulse of the sag detector; notes whether a reset pulse follows
  task automatic sag(input logic inh);
    seen = 1'b0;
    @(posedge pclk) supply_sag_detect <= 1'b1;
    @(posedge pclk) #1 chk(32'(eeprom_inhibit), 32'(inh));
    // A warm reset pulse stands for just this one cycle
    seen |= system_reset;
    @(posedge pclk) supply_sag_detect <= 1'b0;
    repeat (4) begin @(posedge pclk); #1 seen |= system_reset; end
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_flags();
    apb(1'b0, power_control_idx, 8'h00); chk(rd, 32'h30);
    apb(1'b1, power_control_idx, 8'h00);
    apb(1'b0, power_control_idx, 8'h00); chk(rd, 32'h00);
    apb(1'b1, boot_control_idx, 8'h00); chk(32'(boot_source_select), 32'h0);
    apb(1'b0, 12'h004, 8'h00); chk({err, rd[30:0]}, 32'h80000000);
  endtask

  task automatic t_watchdog();
    apb(1'b1, watchdog_control_idx, 8'h3f);
    repeat (3) @(posedge pclk);
    apb(1'b0, watchdog_control_idx, 8'h00); chk(rd, 32'h2f);
    apb(1'b1, watchdog_control_idx, 8'h00);
    apb(1'b0, watchdog_control_idx, 8'h00); chk(rd, 32'h00);
    apb(1'b1, watchdog_control_idx, 8'h2a);
    apb(1'b0, watchdog_control_idx, 8'h00); chk(rd, 32'h2a);
  endtask

  task automatic t_sag_reset();
    sag(1'b1); chk(32'(seen), 32'h1);
    chk(32'(boot_source_select), 32'h0);
    apb(1'b0, power_control_idx, 8'h00); chk(rd & 32'h20, 32'h20);
    apb(1'b0, watchdog_control_idx, 8'h00); chk(rd, 32'h00);
  endtask

  task automatic t_sag_irq();
    chk(32'(boot_source_select), 32'h1);
    apb(1'b1, power_control_idx, 8'h00);
    apb(1'b1, interrupt_enable_reg_idx, 8'h40);
    sag(1'b0); chk(32'(seen), 32'h0);
    chk(32'(supply_sag_irq), 32'h0);
    apb(1'b0, power_control_idx, 8'h00); chk(rd & 32'h20, 32'h20);
    apb(1'b1, interrupt_enable_reg_idx, 8'hc0); chk(32'(supply_sag_irq), 32'h1);
    apb(1'b1, interrupt_priority_reg_idx, 8'h40); chk(32'(supply_sag_irq_high), 32'h1);
    apb(1'b1, interrupt_priority_reg_idx, 8'h00); chk(32'(supply_sag_irq_high), 32'h0);
    @(posedge pclk) core_power_down <= 1'b1;
    @(posedge pclk) #1 chk(32'(wake_request), 32'h1);
    @(posedge pclk) irq_ack <= 1'b1;
    @(posedge pclk) irq_ack <= 1'b0;
    @(posedge pclk) #1 chk(32'(supply_sag_irq), 32'h0);
    core_power_down <= 1'b0;
  endtask

  // Supply dip: a cold start again without the reset pin
  task automatic t_brownout();
    apb(1'b1, boot_control_idx, 8'h00);
    @(posedge pclk) power_ok <= 1'b0;
    repeat (3) @(posedge pclk);
    power_ok <= 1'b1;
    n = 0;
    do begin @(posedge pclk); #1 n++; end while (system_reset === 1'b1 && n < 5000);
    chk(32'(n >= por_n + ext_n && n <= por_n + ext_n + 3), 32'h1);
    chk(32'(boot_source_select), 32'h1);
    apb(1'b0, power_control_idx, 8'h00); chk(rd & 32'h30, 32'h30);
  endtask

  // ------------------------------------------------------------
  // Main sequence and hang guard
  // ------------------------------------------------------------
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      test_done();
    end
  end

  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 12'h000; pwdata = 32'h0; options = 3'b011; power_ok = 1'b1;
    supply_sag_detect = 1'b0; core_idle = 1'b0; core_power_down = 1'b0; irq_ack = 1'b0;
    error_cnt = 0; total_checks = 0; cyc = 0;
    power_up(3'b011, por_n);
    t_flags();
    t_watchdog();
    t_sag_reset();
    power_up(3'b100, por_n + ext_n);
    t_sag_irq();
    t_brownout();
    test_done();
  end
endmodule
